// File: hw/tcp_pkg.sv
package tcp_pkg;
  // ****************************************************
  // opcodes and fields
  // ****************************************************
  localparam logic [11:0] OPC_LOAD_CONFIG = 12'h002;
  localparam logic [11:0] OPC_WDT_CLEAR = 12'h004;
  localparam logic [7:0] CONFIG_RESET = 8'hFF;
  localparam int CFG_CLK_SRC = 5;
  localparam int CFG_EDGE = 4;
  localparam int CFG_ASSIGN = 3;
  localparam int CMP_CLK_SEL = 4;
  localparam int CMP_OUT_EN = 6;
  localparam logic [1:0] WRITE_HOLD_CYCLES = 2'h2;

  // count source selection
  typedef enum logic [1:0] {
    TCP_SRC_CYCLE = 2'b00,
    TCP_SRC_PIN = 2'b01,
    TCP_SRC_CMP = 2'b10
  } tcp_src_e;

  // configuration register layout
  typedef struct packed {
    logic pin_wake_disable;
    logic pullup_disable;
    logic clock_source_select;
    logic source_edge_select;
    logic prescaler_assign;
    logic [2:0] prescale_rate;
  } tcp_config_s;
endpackage : tcp_pkg

// File: hw/tcp_timer.sv
`timescale 1ns/10ps
module tcp_timer
  import tcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cycle_en,
  input wire logic [11:0] opcode,
  input wire logic opcode_valid,
  input wire logic [7:0] work_reg,
  input wire logic [7:0] comparator_control,
  input wire logic count_write,
  input wire logic [7:0] count_wdata,
  input wire logic external_count_input,
  input wire logic comparator_out,
  input wire logic watchdog_tick,
  output logic [7:0] timer_count_value,
  output logic [7:0] config_value,
  output logic comparator_output_pin,
  output logic comparator_output_pin_oe,
  output logic watchdog_event,
  output logic watchdog_clear
);
  // ****************************************************
  // configuration register
  // ****************************************************
  tcp_config_s cfg_reg;
  logic load_cfg;
  logic wdt_clr_op;

  assign load_cfg = opcode_valid && cycle_en && opcode == OPC_LOAD_CONFIG;
  assign wdt_clr_op = opcode_valid && cycle_en && opcode == OPC_WDT_CLEAR;

  // write-only config; reset forces ones
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= tcp_config_s'(CONFIG_RESET);
    end else if (load_cfg) begin
      cfg_reg <= tcp_config_s'(work_reg);
    end
  end
  assign config_value = cfg_reg;

  // clear pulse toward the watchdog itself
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      watchdog_clear <= 1'b0;
    end else begin
      watchdog_clear <= wdt_clr_op;
    end
  end

  // ****************************************************
  // source selection and pin drive
  // ****************************************************
  tcp_src_e src;
  logic cmp_sel;
  logic cmp_oen;

  assign cmp_sel = comparator_control[CMP_CLK_SEL];
  assign cmp_oen = comparator_control[CMP_OUT_EN];

  // pick the count source from the two select bits
  always_comb begin
    if (!cfg_reg.clock_source_select) begin
      src = TCP_SRC_CYCLE;
    end else if (!cmp_sel) begin
      src = TCP_SRC_CMP;
    end else begin
      src = TCP_SRC_PIN;
    end
  end

  // comparator fed back through the pin; input stays live
  assign comparator_output_pin_oe = cfg_reg.clock_source_select &&
    cmp_sel && !cmp_oen;
  assign comparator_output_pin = comparator_out;

  // ****************************************************
  // edge detection
  // ****************************************************
  logic raw_level;
  logic level_d_reg;
  logic edge_seen;

  // pin mode reads the pad even while we drive it, so feedback is counted
  assign raw_level = (src == TCP_SRC_CMP) ? comparator_out :
    external_count_input;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level_d_reg <= 1'b0;
    end else begin
      level_d_reg <= raw_level;
    end
  end

  // rising when edge bit zero, falling when one
  assign edge_seen = cfg_reg.source_edge_select ?
    (level_d_reg && !raw_level) : (!level_d_reg && raw_level);

  // ****************************************************
  // prescaler
  // ****************************************************
  logic [7:0] pre_reg;
  logic [7:0] pre_next;
  logic src_tick;
  logic pre_in;
  logic pre_out;
  logic timer_tick;
  logic [8:0] sel_mask;
  logic pre_clear;

  assign src_tick = (src == TCP_SRC_CYCLE) ? cycle_en : edge_seen;
  // the single divider is fed only by its owner
  assign pre_in = cfg_reg.prescaler_assign ? watchdog_tick : src_tick;
  assign pre_clear = wdt_clr_op ||
    (count_write && !cfg_reg.prescaler_assign);
  assign pre_next = pre_reg + 8'h01;

  // ratio 2^(rate+1) for timer, 2^rate for watchdog
  assign sel_mask = cfg_reg.prescaler_assign ?
    (9'h001 << cfg_reg.prescale_rate) :
    (9'h002 << cfg_reg.prescale_rate);

  // internal count, no software path to it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_reg <= 8'h00;
    end else if (pre_clear) begin
      pre_reg <= 8'h00;
    end else if (pre_in) begin
      pre_reg <= pre_next;
    end
  end

  // carry out of the selected stage
  always_comb begin
    pre_out = 1'b0;
    if (pre_in) begin
      if (sel_mask[0]) begin
        pre_out = 1'b1;
      end else begin
        pre_out = ((pre_next & (sel_mask[7:0] - 8'h01)) == 8'h00) ||
          (sel_mask[8] && pre_next == 8'h00);
      end
    end
  end

  assign timer_tick = cfg_reg.prescaler_assign ? src_tick : pre_out;
  assign watchdog_event = cfg_reg.prescaler_assign ? pre_out : 1'b0;

  // ****************************************************
  // count register
  // ****************************************************
  logic [7:0] count_reg;
  logic [1:0] hold_reg;

  // inhibit window after a software write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_reg <= 2'h0;
    end else if (count_write) begin
      hold_reg <= WRITE_HOLD_CYCLES;
    end else if (cycle_en && hold_reg != 2'h0) begin
      hold_reg <= hold_reg - 2'h1;
    end
  end

  // write wins over a tick in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= 8'h00;
    end else if (count_write) begin
      count_reg <= count_wdata;
    end else if (timer_tick && hold_reg == 2'h0) begin
      count_reg <= count_reg + 8'h01;
    end
  end
  assign timer_count_value = count_reg;

  // ****************************************************
  // checks
  // ****************************************************
  cfg_reset_a: assert property (@(posedge clk)
    $fell(rst) |-> cfg_reg == tcp_config_s'(CONFIG_RESET))
    else $error("config not all ones after reset");
  cfg_load_a: assert property (@(posedge clk) disable iff (rst)
    load_cfg |=> cfg_reg == tcp_config_s'($past(work_reg)))
    else $error("config load failed");
  write_hold_a: assert property (@(posedge clk) disable iff (rst)
    count_write ##1 !count_write |-> count_reg == $past(count_wdata))
    else $error("count moved right after write");
  wrap_a: assert property (@(posedge clk) disable iff (rst)
    count_reg == 8'hFF && timer_tick && hold_reg == 2'h0 && !count_write
    |=> count_reg == 8'h00)
    else $error("count did not wrap");
  pre_clear_a: assert property (@(posedge clk) disable iff (rst)
    pre_clear |=> pre_reg == 8'h00)
    else $error("prescaler not cleared");
  timer_direct_a: assert property (@(posedge clk) disable iff (rst)
    src == TCP_SRC_CYCLE && cfg_reg.prescaler_assign && cycle_en &&
    hold_reg == 2'h0 && !count_write && !load_cfg
    |=> count_reg == $past(count_reg) + 8'h01)
    else $error("timer missed a cycle");
  exclusive_a: assert property (@(posedge clk) disable iff (rst)
    !(watchdog_event && !cfg_reg.prescaler_assign))
    else $error("prescaler shared");
  pin_drive_a: assert property (@(posedge clk) disable iff (rst)
    comparator_output_pin_oe |-> cfg_reg.clock_source_select &&
    cmp_sel && !cmp_oen)
    else $error("pin driven out of mode");
  wdt_clear_a: assert property (@(posedge clk) disable iff (rst)
    wdt_clr_op |=> watchdog_clear && pre_reg == 8'h00)
    else $error("watchdog clear missing");

  // ****************************************************
  // further checks per rule
  // ****************************************************
  // a write always restarts the full inhibit window
  hold_load_a: assert property (@(posedge clk) disable iff (rst)
    count_write |=> hold_reg == WRITE_HOLD_CYCLES)
    else $error("hold window not armed");

  // no tick may slip through while the window is open
  // note: a new write inside the window restarts it
  hold_block_a: assert property (@(posedge clk) disable iff (rst)
    hold_reg != 2'h0 && !count_write |=> count_reg == $past(count_reg))
    else $error("count moved inside hold");

  // rising edges only when the edge bit is clear
  rise_edge_a: assert property (@(posedge clk) disable iff (rst)
    !cfg_reg.source_edge_select && edge_seen |->
    raw_level && !level_d_reg)
    else $error("wrong edge counted, rising");

  // falling edges only when the edge bit is set
  fall_edge_a: assert property (@(posedge clk) disable iff (rst)
    cfg_reg.source_edge_select && edge_seen |->
    !raw_level && level_d_reg)
    else $error("wrong edge counted, falling");

  // both select bits set picks the pin source
  src_pin_a: assert property (@(posedge clk) disable iff (rst)
    cfg_reg.clock_source_select && cmp_sel |-> src == TCP_SRC_PIN)
    else $error("pin source not selected");

  // comparator path ignores the out enable bit entirely
  src_cmp_a: assert property (@(posedge clk) disable iff (rst)
    cfg_reg.clock_source_select && !cmp_sel |-> src == TCP_SRC_CMP)
    else $error("comparator source not selected");

  // timer mode overrides every comparator setting
  src_cycle_a: assert property (@(posedge clk) disable iff (rst)
    !cfg_reg.clock_source_select |-> src == TCP_SRC_CYCLE)
    else $error("cycle source not selected");

  // pin input stays live in both pin modes
  // so an outside driver fighting us would be seen too
  pin_live_a: assert property (@(posedge clk) disable iff (rst)
    src == TCP_SRC_PIN |-> raw_level == external_count_input)
    else $error("pin input not sampled");

  // timer source must not move a divider the watchdog owns
  pre_wdt_own_a: assert property (@(posedge clk) disable iff (rst)
    cfg_reg.prescaler_assign && !pre_clear && !watchdog_tick
    |=> pre_reg == $past(pre_reg))
    else $error("prescaler moved by timer");

  // watchdog ticks must not move a divider the timer owns
  pre_tmr_own_a: assert property (@(posedge clk) disable iff (rst)
    !cfg_reg.prescaler_assign && !pre_clear && !src_tick
    |=> pre_reg == $past(pre_reg))
    else $error("prescaler moved by watchdog");

  // without the divider the timer sees its source directly
  tick_direct_a: assert property (@(posedge clk) disable iff (rst)
    cfg_reg.prescaler_assign |-> timer_tick == src_tick)
    else $error("timer tick not direct");

  // top timer ratio only fires when the divider rolls over
  ratio_top_a: assert property (@(posedge clk) disable iff (rst)
    !cfg_reg.prescaler_assign && cfg_reg.prescale_rate == 3'h7 &&
    timer_tick |-> pre_next == 8'h00)
    else $error("timer ratio 256 broken");

  // lowest watchdog ratio passes every base tick
  wdt_ratio_a: assert property (@(posedge clk) disable iff (rst)
    cfg_reg.prescaler_assign && cfg_reg.prescale_rate == 3'h0
    |-> watchdog_event == watchdog_tick)
    else $error("watchdog ratio one broken");

  // divider steps by one per input tick
  // a clear in the same cycle wins so realignment is exact
  pre_step_a: assert property (@(posedge clk) disable iff (rst)
    !pre_clear && pre_in |=> pre_reg == $past(pre_reg) + 8'h01)
    else $error("prescaler step wrong");

  // config changes only through the load opcode
  cfg_stable_a: assert property (@(posedge clk) disable iff (rst)
    !load_cfg |=> cfg_reg == $past(cfg_reg))
    else $error("config changed without load");

  // software write lands whatever the tick does
  count_write_a: assert property (@(posedge clk) disable iff (rst)
    count_write |=> count_reg == $past(count_wdata))
    else $error("count write lost");

  hold_c: cover property (@(posedge clk) disable iff (rst)
    count_write ##1 hold_reg == WRITE_HOLD_CYCLES);

  wrap_c: cover property (@(posedge clk) disable iff (rst)
    count_reg == 8'hFF ##1 count_reg == 8'h00);
  pin_c: cover property (@(posedge clk) disable iff (rst)
    src == TCP_SRC_PIN && edge_seen);
  cmp_c: cover property (@(posedge clk) disable iff (rst)
    src == TCP_SRC_CMP && timer_tick);
  wdt_c: cover property (@(posedge clk) disable iff (rst)
    watchdog_event);
endmodule : tcp_timer

// File: tb/tcp_src_model.sv
`timescale 1ns/10ps
// ****
// count source model
// ****
// toggles pin or comparator level on request; holds between requests
module tcp_src_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic sel_cmp,
  output logic pin_level,
  output logic cmp_level
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_level <= 1'b0;
      cmp_level <= 1'b0;
    end else if (fire) begin
      if (sel_cmp) cmp_level <= ~cmp_level;
      else pin_level <= ~pin_level;
    end
  end
endmodule : tcp_src_model

// File: tb/timer_counter_prescaler_tb.sv
`timescale 1ns/10ps
module timer_counter_prescaler_tb;
  import tcp_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, ov = 0, cw = 0, wt = 0, fire = 0;
  logic sel = 0;
  logic [11:0] opc = '0;
  logic [7:0] w = '0, cc = '0, cd = '0, cnt, cfg, c0, seen;
  logic cop, coe, wev, wclr, pin, cmpl, ext;
  int failures = 0, n_compared = 0;
  logic [7:0] cc_t[5] = '{8'h50, 8'h50, 8'h40, 8'h40, 8'h10};
  logic [7:0] cf_t[5] = '{8'h28, 8'h38, 8'h28, 8'h28, 8'h28};
  logic [7:0] ex_t[5] = '{8'h02, 8'h02, 8'h02, 8'h00, 8'h02};
  logic [4:0] sl_t = 5'b10100;
  // pin level: the block drives it while its enable is high
  assign ext = coe ? cop : pin;
  tcp_timer tcp_timer_inst (.clk(clk), .rst(rst), .cycle_en(cyc),
    .opcode(opc), .opcode_valid(ov), .work_reg(w),
    .comparator_control(cc), .count_write(cw), .count_wdata(cd),
    .external_count_input(ext), .comparator_out(cmpl),
    .watchdog_tick(wt), .timer_count_value(cnt), .config_value(cfg),
    .comparator_output_pin(cop), .comparator_output_pin_oe(coe),
    .watchdog_event(wev), .watchdog_clear(wclr));
  tcp_src_model tcp_src_model_inst (.clk(clk), .rst(rst), .fire(fire),
    .sel_cmp(sel), .pin_level(pin), .cmp_level(cmpl));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", what, e, s);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic op(input logic [11:0] c, input logic [7:0] v);
    @(posedge clk) {opc, w, ov} <= {c, v, 1'b1};
    @(posedge clk) ov <= 1'b0;
    #1;
  endtask : op
  task automatic wr(input logic [7:0] v);
    @(posedge clk) {cd, cw} <= {v, 1'b1};
    @(posedge clk) cw <= 1'b0;
    #1;
  endtask : wr
  task automatic summarize;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  // hang guard, a few times the expected run length
  initial begin
    #30000;
    failures++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    cyc <= 1'b1;
    #1;
    check("cfg reset", cfg, CONFIG_RESET);
    op(OPC_LOAD_CONFIG, 8'h08);
    check("cfg load", cfg, 8'h08);
    wr(8'hFD);
    check("count wr", cnt, 8'hFD);
    tick(2);
    check("count hold", cnt, 8'hFD);
    tick(1);
    check("count run", cnt, 8'hFE);
    tick(2);
    check("count wrap", cnt, 8'h00);
    $display("test timer done");
    op(OPC_WDT_CLEAR, 8'h00);
    seen = {7'h0, wclr};
    tick(1);
    seen |= {7'h0, wclr};
    check("wdt clear", seen, 8'h01);
    // each rate: two counts after twice its ratio of cycles
    for (int r = 0; r < 8; r++) begin
      op(OPC_LOAD_CONFIG, 8'(r));
      wr(8'h00);
      tick(4);
      c0 = cnt;
      tick(4 << r);
      check("ratio", cnt - c0, 8'h02);
    end
    $display("test prescaler done");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) cc <= cc_t[i];
      op(OPC_LOAD_CONFIG, cf_t[i]);
      tick(4);
      c0 = cnt;
      repeat (4) begin
        @(posedge clk) {fire, sel} <= {1'b1, sl_t[i]};
        @(posedge clk) fire <= 1'b0;
        tick(4);
      end
      check("edges", cnt - c0, ex_t[i]);
    end
    check("pin oe", {7'h0, coe}, 8'h01);
    $display("test counter done");
    op(OPC_LOAD_CONFIG, 8'h08);
    @(posedge clk) wt <= 1'b1;
    #1 check("wdt ev", {7'h0, wev}, 8'h01);
    @(posedge clk) wt <= 1'b0;
    op(OPC_WDT_CLEAR, 8'h00);
    op(OPC_LOAD_CONFIG, 8'h00);
    @(posedge clk) wt <= 1'b1;
    #1 check("wdt off", {7'h0, wev}, 8'h00);
    @(posedge clk) wt <= 1'b0;
    $display("test watchdog done");
    summarize();
  end
endmodule : timer_counter_prescaler_tb
